// ---- hdl/audio_pm_pkg.sv ----
// Purpose: Shared constants and types for the power-management register bank
// Assumes: 16-bit registers, 8-bit register index carried on the two-wire bus
// Notes:   Struct layouts fix every field position of the two power registers
`default_nettype none

package audio_pm_pkg;

  // Register indices
  localparam logic [7:0] ADDR_RESET_IDENT = 8'h00;
  localparam logic [7:0] ADDR_POWER_FIRST = 8'h01;
  localparam logic [7:0] ADDR_POWER_SECOND = 8'h02;

  // Reset values and writable-bit masks
  localparam logic [15:0] POWER_FIRST_RESET = 16'h0006;
  localparam logic [15:0] POWER_SECOND_RESET = 16'h6000;
  localparam logic [15:0] POWER_FIRST_WMASK = 16'h130F;
  localparam logic [15:0] POWER_SECOND_WMASK = 16'h60F0;

  // Identity values (arbitrary, not tied to any real part)
  localparam logic [6:0] DEVICE_ADDR_DEFAULT = 7'h1A;
  localparam logic [15:0] CHIP_ID_DEFAULT = 16'h5A5A;

  // Serial bit counter positions
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;

  // Synchroniser idle levels for {sensor, data line, clock line}
  localparam logic [2:0] SYNC_RESET = 3'h3;

  typedef struct packed {
    logic [2:0] rsv_15_13;
    logic speaker_out_enable;
    logic [1:0] rsv_11_10;
    logic left_phone_stage_enable;
    logic right_phone_stage_enable;
    logic [3:0] rsv_7_4;
    logic oscillator_enable;
    logic [1:0] midrail_divider_select;
    logic analogue_bias_enable;
  } power_first_t;

  typedef struct packed {
    logic over_temperature_flag;
    logic thermal_sensor_enable;
    logic thermal_output_cutoff;
    logic [4:0] rsv_12_8;
    logic input_one_a_amp_enable;
    logic input_one_b_amp_enable;
    logic input_two_a_amp_enable;
    logic input_two_b_amp_enable;
    logic [3:0] rsv_3_0;
  } power_second_t;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_DEV = 7'h02,
    ST_REG = 7'h04,
    ST_WHI = 7'h08,
    ST_WLO = 7'h10,
    ST_RHI = 7'h20,
    ST_RLO = 7'h40
  } link_state_t;

endpackage : audio_pm_pkg

`default_nettype wire

// ---- hdl/two_stage_sync.sv ----
// Purpose: Two flip-flop synchroniser for asynchronous level inputs
// Assumes: Synchronous active-low reset on the sampling clock
// Notes:   Only the second stage may be read by other logic
`default_nettype none

module two_stage_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Levels
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      meta_reg <= RESET_VALUE;
      q_o <= RESET_VALUE;
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end

endmodule : two_stage_sync

`default_nettype wire

// ---- hdl/audio_power_mgmt_regs.sv ----
// Purpose: Power-management and reset registers behind a two-wire control slave
// Assumes: mclk_i at 125 MHz, far above the bus clock; open-drain data line
// Notes:   Writes are address, high byte, low byte; reads return high then low byte
`default_nettype none

module audio_power_mgmt_regs #(
  parameter logic [6:0] DEVICE_ADDR = audio_pm_pkg::DEVICE_ADDR_DEFAULT,
  parameter logic [15:0] CHIP_ID = audio_pm_pkg::CHIP_ID_DEFAULT
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Two-wire control bus, data line as open drain
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Thermal sensor level, asynchronous
  input wire logic over_temp_i,
  // Power controls
  output logic soft_reset_o,
  output logic speaker_out_enable_o,
  output logic left_phone_stage_enable_o,
  output logic right_phone_stage_enable_o,
  output logic oscillator_enable_o,
  output logic [1:0] midrail_divider_select_o,
  output logic analogue_bias_enable_o,
  output logic thermal_sensor_enable_o,
  output logic input_one_a_amp_enable_o,
  output logic input_one_b_amp_enable_o,
  output logic input_two_a_amp_enable_o,
  output logic input_two_b_amp_enable_o,
  // Thermal status
  output logic over_temperature_flag_o,
  output logic output_cutoff_o
);

  logic [2:0] sync_q;
  logic scl_d_reg;
  logic sda_d_reg;
  audio_pm_pkg::link_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] rx_reg;
  logic [7:0] tx_reg;
  logic [7:0] reg_addr_reg;
  logic [7:0] data_hi_reg;
  logic [15:0] rd_word_reg;
  logic master_ack_reg;
  logic wr_pulse_reg;
  logic armed_reg;
  logic flag_reg;
  audio_pm_pkg::power_first_t pwr1_reg;
  audio_pm_pkg::power_second_t pwr2_reg;

  two_stage_sync #(
    .WIDTH(3),
    .RESET_VALUE(audio_pm_pkg::SYNC_RESET)
  ) u_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .d_i({over_temp_i, sda_i, scl_i}),
    .q_o(sync_q)
  );

  wire scl_s = sync_q[0];
  wire sda_s = sync_q[1];
  wire temp_s = sync_q[2];

  // Bus conditions
  wire scl_rise = scl_s & ~scl_d_reg;
  wire scl_fall = ~scl_s & scl_d_reg;
  wire start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire stop_cond = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  wire reading = (state_reg == audio_pm_pkg::ST_RHI) || (state_reg == audio_pm_pkg::ST_RLO);
  wire addr_match = (rx_reg[7:1] == DEVICE_ADDR);
  wire ack_byte = !reading && ((state_reg != audio_pm_pkg::ST_DEV) || addr_match);

  // Register decode
  wire [15:0] wr_data = {data_hi_reg, rx_reg};
  wire sel_ident = (reg_addr_reg == audio_pm_pkg::ADDR_RESET_IDENT);
  wire sel_first = (reg_addr_reg == audio_pm_pkg::ADDR_POWER_FIRST);
  wire sel_second = (reg_addr_reg == audio_pm_pkg::ADDR_POWER_SECOND);
  wire write_reset = wr_pulse_reg & sel_ident;
  wire [15:0] second_view = {flag_reg, pwr2_reg[14:0]};
  wire [15:0] read_word = sel_ident ? CHIP_ID :
                          sel_first ? pwr1_reg :
                          sel_second ? second_view : 16'h0000;
  wire cutoff = flag_reg & pwr2_reg.thermal_sensor_enable & pwr2_reg.thermal_output_cutoff;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  // Serial slave: bits are taken on clock rise, the data line changes after clock fall
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state_reg <= audio_pm_pkg::ST_IDLE;
      bit_cnt_reg <= 4'h0;
      rx_reg <= 8'h00;
      tx_reg <= 8'h00;
      reg_addr_reg <= 8'h00;
      data_hi_reg <= 8'h00;
      rd_word_reg <= 16'h0000;
      master_ack_reg <= 1'b0;
      wr_pulse_reg <= 1'b0;
      armed_reg <= 1'b0;
      sda_oe_o <= 1'b0;
    end else begin
      wr_pulse_reg <= 1'b0;
      if (start_cond) begin
        state_reg <= audio_pm_pkg::ST_DEV;
        bit_cnt_reg <= 4'h0;
        armed_reg <= 1'b0;
        sda_oe_o <= 1'b0;
      end else if (stop_cond) begin
        state_reg <= audio_pm_pkg::ST_IDLE;
        sda_oe_o <= 1'b0;
      end else if (state_reg != audio_pm_pkg::ST_IDLE) begin
        if (scl_rise) begin
          armed_reg <= 1'b1;
          if (bit_cnt_reg != audio_pm_pkg::ACK_SLOT) begin
            rx_reg <= {rx_reg[6:0], sda_s};
          end else begin
            master_ack_reg <= ~sda_s;
          end
        // The clock fall right after a start carries no bit, so it must not advance the count
        end else if (scl_fall && armed_reg) begin
          if (bit_cnt_reg < audio_pm_pkg::LAST_DATA_BIT) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (reading) begin
              tx_reg <= {tx_reg[6:0], 1'b0};
              sda_oe_o <= ~tx_reg[6];
            end
          end else if (bit_cnt_reg == audio_pm_pkg::LAST_DATA_BIT) begin
            bit_cnt_reg <= audio_pm_pkg::ACK_SLOT;
            sda_oe_o <= ack_byte;
            case (state_reg)
              audio_pm_pkg::ST_DEV: begin
                rd_word_reg <= read_word;
                if (!addr_match) begin
                  state_reg <= audio_pm_pkg::ST_IDLE;
                end
              end
              audio_pm_pkg::ST_REG: reg_addr_reg <= rx_reg;
              audio_pm_pkg::ST_WHI: data_hi_reg <= rx_reg;
              audio_pm_pkg::ST_WLO: wr_pulse_reg <= 1'b1;
              default: ;
            endcase
          end else begin
            bit_cnt_reg <= 4'h0;
            sda_oe_o <= 1'b0;
            case (state_reg)
              audio_pm_pkg::ST_DEV: begin
                if (rx_reg[0]) begin
                  state_reg <= audio_pm_pkg::ST_RHI;
                  tx_reg <= rd_word_reg[15:8];
                  sda_oe_o <= ~rd_word_reg[15];
                end else begin
                  state_reg <= audio_pm_pkg::ST_REG;
                end
              end
              audio_pm_pkg::ST_REG: state_reg <= audio_pm_pkg::ST_WHI;
              audio_pm_pkg::ST_WHI: state_reg <= audio_pm_pkg::ST_WLO;
              audio_pm_pkg::ST_WLO: state_reg <= audio_pm_pkg::ST_WHI;
              audio_pm_pkg::ST_RHI: begin
                if (master_ack_reg) begin
                  state_reg <= audio_pm_pkg::ST_RLO;
                  tx_reg <= rd_word_reg[7:0];
                  sda_oe_o <= ~rd_word_reg[7];
                end else begin
                  state_reg <= audio_pm_pkg::ST_IDLE;
                end
              end
              audio_pm_pkg::ST_RLO: begin
                if (master_ack_reg) begin
                  state_reg <= audio_pm_pkg::ST_RHI;
                  tx_reg <= rd_word_reg[15:8];
                  sda_oe_o <= ~rd_word_reg[15];
                end else begin
                  state_reg <= audio_pm_pkg::ST_IDLE;
                end
              end
              default: state_reg <= audio_pm_pkg::ST_IDLE;
            endcase
          end
        end
      end
    end
  end

  // Soft reset returns both power registers to their defaults in the cycle after the write
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || write_reset) begin
      pwr1_reg <= audio_pm_pkg::POWER_FIRST_RESET;
      pwr2_reg <= audio_pm_pkg::POWER_SECOND_RESET;
    end else if (wr_pulse_reg && sel_first) begin
      pwr1_reg <= wr_data & audio_pm_pkg::POWER_FIRST_WMASK;
    end else if (wr_pulse_reg && sel_second) begin
      pwr2_reg <= wr_data & audio_pm_pkg::POWER_SECOND_WMASK;
    end
  end

  // A disabled sensor reports normal temperature
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      flag_reg <= 1'b0;
      soft_reset_o <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      flag_reg <= temp_s & pwr2_reg.thermal_sensor_enable;
      soft_reset_o <= write_reset;
      sda_o <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      speaker_out_enable_o <= 1'b0;
      left_phone_stage_enable_o <= 1'b0;
      right_phone_stage_enable_o <= 1'b0;
      oscillator_enable_o <= 1'b0;
      midrail_divider_select_o <= 2'h0;
      analogue_bias_enable_o <= 1'b0;
      thermal_sensor_enable_o <= 1'b0;
      input_one_a_amp_enable_o <= 1'b0;
      input_one_b_amp_enable_o <= 1'b0;
      input_two_a_amp_enable_o <= 1'b0;
      input_two_b_amp_enable_o <= 1'b0;
      over_temperature_flag_o <= 1'b0;
      output_cutoff_o <= 1'b0;
    end else begin
      speaker_out_enable_o <= pwr1_reg.speaker_out_enable & ~cutoff;
      left_phone_stage_enable_o <= pwr1_reg.left_phone_stage_enable & ~cutoff;
      right_phone_stage_enable_o <= pwr1_reg.right_phone_stage_enable & ~cutoff;
      oscillator_enable_o <= pwr1_reg.oscillator_enable;
      midrail_divider_select_o <= pwr1_reg.midrail_divider_select;
      analogue_bias_enable_o <= pwr1_reg.analogue_bias_enable;
      thermal_sensor_enable_o <= pwr2_reg.thermal_sensor_enable;
      input_one_a_amp_enable_o <= pwr2_reg.input_one_a_amp_enable;
      input_one_b_amp_enable_o <= pwr2_reg.input_one_b_amp_enable;
      input_two_a_amp_enable_o <= pwr2_reg.input_two_a_amp_enable;
      input_two_b_amp_enable_o <= pwr2_reg.input_two_b_amp_enable;
      over_temperature_flag_o <= flag_reg;
      output_cutoff_o <= cutoff;
    end
  end

endmodule : audio_power_mgmt_regs

`default_nettype wire

// ---- dv/audio_pm_sva.sv ----
// Purpose: Port assertions for the power register bank
// Assumes: One clock, synchronous active-low reset
// Notes: Bounds allow for the two-flop synchronisers
`default_nettype none
module audio_pm_sva (
  // Clock, reset, inputs
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic over_temp_i,
  // Outputs
  input wire logic soft_reset_o,
  input wire logic speaker_out_enable_o,
  input wire logic left_phone_stage_enable_o,
  input wire logic right_phone_stage_enable_o,
  input wire logic oscillator_enable_o,
  input wire logic [1:0] midrail_divider_select_o,
  input wire logic analogue_bias_enable_o,
  input wire logic thermal_sensor_enable_o,
  input wire logic input_one_a_amp_enable_o,
  input wire logic input_one_b_amp_enable_o,
  input wire logic input_two_a_amp_enable_o,
  input wire logic input_two_b_amp_enable_o,
  input wire logic over_temperature_flag_o,
  input wire logic output_cutoff_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  logic [8:0] cfg;
  logic hot;
  logic mute;
  assign cfg = {oscillator_enable_o, midrail_divider_select_o, analogue_bias_enable_o, thermal_sensor_enable_o,
    input_one_a_amp_enable_o, input_one_b_amp_enable_o, input_two_a_amp_enable_o, input_two_b_amp_enable_o};
  assign hot = over_temperature_flag_o;
  assign mute = !(speaker_out_enable_o || left_phone_stage_enable_o || right_phone_stage_enable_o);
  property p_pulse; soft_reset_o |=> !soft_reset_o; endproperty
  a_pulse: assert property (p_pulse) else $error("reset pulse too long");
  property p_dflt; soft_reset_o |-> ##[1:2] (cfg == 9'h0D0); endproperty
  a_dflt: assert property (p_dflt) else $error("defaults not restored");
  // Writes land in the low phase, so a long high phase sees no change
  property p_hold; scl_i [*8] |-> $stable(cfg); endproperty
  a_hold: assert property (p_hold) else $error("enable moved");
  property p_up; (over_temp_i && thermal_sensor_enable_o) [*6] |-> hot; endproperty
  a_up: assert property (p_up) else $error("flag missing");
  property p_dn; (!over_temp_i) [*6] |-> !hot; endproperty
  a_dn: assert property (p_dn) else $error("flag stuck");
  property p_src; output_cutoff_o |-> hot || $past(hot); endproperty
  a_src: assert property (p_src) else $error("cutoff without flag");
  property p_mute; output_cutoff_o [*2] |-> mute; endproperty
  a_mute: assert property (p_mute) else $error("outputs live in cutoff");
  property p_off; (!thermal_sensor_enable_o) [*4] |-> !(output_cutoff_o || hot); endproperty
  a_off: assert property (p_off) else $error("sensor off yet hot");
  c_srst: cover property (soft_reset_o);
  c_cut: cover property (output_cutoff_o ##1 !output_cutoff_o);
  c_hot: cover property (hot && !output_cutoff_o);
endmodule : audio_pm_sva
bind audio_power_mgmt_regs audio_pm_sva u_sva (.mclk_i, .rst_n_i, .scl_i, .over_temp_i, .soft_reset_o,
  .speaker_out_enable_o, .left_phone_stage_enable_o, .right_phone_stage_enable_o, .oscillator_enable_o,
  .midrail_divider_select_o, .analogue_bias_enable_o, .thermal_sensor_enable_o, .input_one_a_amp_enable_o,
  .input_one_b_amp_enable_o, .input_two_a_amp_enable_o, .input_two_b_amp_enable_o, .over_temperature_flag_o,
  .output_cutoff_o);
`default_nettype wire

// ---- dv/i2c_host_model.sv ----
// Purpose: Two-wire host driving the control bus
// Assumes: Pull-up outside on data; host only pulls data low, drives clock both ways
// Notes: Phases of Q mclk, far above the minimum
`default_nettype none
module i2c_host_model #(parameter logic [6:0] DEV = 7'h00) (
  // Bus
  input wire logic mclk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int Q = 8;
  logic nak;
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
    nak = 1'b0;
  end
  task automatic ph(input logic c, input logic l);
    scl_o <= c;
    sda_low_o <= l;
    repeat (Q) @(posedge mclk_i);
  endtask : ph
  task automatic seq(input logic [7:0] p);
    for (int i = 3; i >= 0; i--) ph(p[2*i+1], p[2*i]);
  endtask : seq
  // Data moves only in the low phase and is sampled mid high phase
  task automatic bitx(input logic b, output logic r);
    ph(1'b0, !b);
    ph(1'b1, !b);
    r = sda_i;
    ph(1'b1, !b);
    ph(1'b0, !b);
  endtask : bitx
  task automatic xfer(input logic [7:0] d, input logic hb, output logic [7:0] q);
    logic a;
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(hb, a);
    nak |= a & hb;
  endtask : xfer
  task automatic acc(input logic rd, input logic [7:0] idx, inout logic [15:0] d);
    logic [7:0] q;
    logic s;
    seq(8'h2D);
    xfer({DEV, 1'b0}, 1'b1, q);
    xfer(idx, 1'b1, q);
    if (rd) seq(8'h2D);
    if (rd) xfer({DEV, 1'b1}, 1'b1, q);
    s = nak;
    xfer(rd ? 8'hFF : d[15:8], !rd, d[15:8]);
    xfer(rd ? 8'hFF : d[7:0], 1'b1, d[7:0]);
    // The final read NACK is the host's own, not a refusal
    if (rd) nak = s;
    seq(8'h7A);
  endtask : acc
endmodule : i2c_host_model
`default_nettype wire

// ---- dv/tb_top.sv ----
// Purpose: Self-checking bench for the power register bank
// Assumes: Host model on the bus, pull-up on data
// Notes: Checked at output pins and by readback
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] ID = 16'hC3A5; // Arbitrary value
  logic mclk_i = 1'b0, rst_n_i = 1'b0, over_temp_i = 1'b0;
  logic scl_i, sda_i, sda_low, sda_o, sda_oe_o, soft_reset_o, speaker_out_enable_o, oscillator_enable_o;
  logic left_phone_stage_enable_o, right_phone_stage_enable_o, analogue_bias_enable_o, thermal_sensor_enable_o;
  logic input_one_a_amp_enable_o, input_one_b_amp_enable_o, input_two_a_amp_enable_o, input_two_b_amp_enable_o;
  logic over_temperature_flag_o, output_cutoff_o;
  logic [1:0] midrail_divider_select_o;
  logic [3:0] th;
  logic [6:0] pm1;
  int n_mismatch = 0, checked = 0, n_srst = 0;
  assign sda_i = !(sda_low || sda_oe_o);
  assign th = {over_temperature_flag_o, output_cutoff_o, left_phone_stage_enable_o, right_phone_stage_enable_o};
  assign pm1 = {speaker_out_enable_o, left_phone_stage_enable_o, right_phone_stage_enable_o, oscillator_enable_o,
    midrail_divider_select_o, analogue_bias_enable_o};
  always #4 mclk_i = ~mclk_i;
  always @(posedge mclk_i) if (soft_reset_o === 1'b1) n_srst++;
  i2c_host_model #(.DEV(audio_pm_pkg::DEVICE_ADDR_DEFAULT)) u_host (.mclk_i, .sda_i, .scl_o(scl_i),
    .sda_low_o(sda_low));
  audio_power_mgmt_regs #(.CHIP_ID(ID)) u_dut (.mclk_i, .rst_n_i, .scl_i, .sda_i, .sda_o, .sda_oe_o, .over_temp_i,
    .soft_reset_o, .speaker_out_enable_o, .left_phone_stage_enable_o, .right_phone_stage_enable_o,
    .oscillator_enable_o, .midrail_divider_select_o, .analogue_bias_enable_o, .thermal_sensor_enable_o,
    .input_one_a_amp_enable_o, .input_one_b_amp_enable_o, .input_two_a_amp_enable_o, .input_two_b_amp_enable_o,
    .over_temperature_flag_o, .output_cutoff_o);
  task automatic complete_run();
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) n_mismatch++;
    if (seen !== exp) $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
  endtask : chk
  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    u_host.acc(1'b0, idx, d);
  endtask : wr
  task automatic rdc(input logic [7:0] idx, input logic [15:0] exp);
    logic [15:0] d;
    u_host.acc(1'b1, idx, d);
    chk(d, exp);
  endtask : rdc
  // Thermal path latency is bounded, never waited on open-ended
  task automatic await(input logic [3:0] exp);
    for (int k = 0; k < 40 && th !== exp; k++) @(posedge mclk_i);
    chk(16'(th), 16'(exp));
    if (th !== exp) complete_run();
  endtask : await
  initial begin
    logic [1:0] m;
    logic [15:0] w;
    repeat (8) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (6) @(posedge mclk_i);
    chk(16'({midrail_divider_select_o, thermal_sensor_enable_o, th[1:0], analogue_bias_enable_o}), 16'h0038);
    rdc(8'h00, ID);
    rdc(8'h01, 16'h0006);
    rdc(8'h02, 16'h6000);
    for (int v = 0; v < 4; v++) begin
      m = 2'(v);
      w = {3'h0, m[1], 2'h0, m[0], m[1], 4'h0, m[0], m, m[0]};
      wr(8'h01, w);
      chk(16'(pm1), 16'({m[1], m[0], m[1], m[0], m, m[0]}));
      rdc(8'h01, w);
    end
    for (int i = 0; i < 4; i++) begin
      wr(8'h02, 16'h6000 | (16'h0080 >> i));
      chk(16'({input_one_a_amp_enable_o, input_one_b_amp_enable_o, input_two_a_amp_enable_o,
        input_two_b_amp_enable_o}), 16'(4'h8 >> i));
    end
    wr(8'h02, 16'hFFFF);
    rdc(8'h02, 16'h60F0);
    over_temp_i <= 1'b1;
    await(4'hC);
    chk(16'(speaker_out_enable_o), 16'h0000);
    rdc(8'h02, 16'hE0F0);
    wr(8'h02, 16'h4000);
    await(4'hB);
    chk(16'(speaker_out_enable_o), 16'h0001);
    wr(8'h02, 16'h2000);
    await(4'h3);
    over_temp_i <= 1'b0;
    wr(8'h00, 16'h1234);
    rdc(8'h01, 16'h0006);
    rdc(8'h02, 16'h6000);
    chk(16'(n_srst), 16'h0001);
    chk(16'({u_host.nak, sda_o}), 16'h0000);
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
